// >>> hw/fcmc_pkg.sv
package fcmc_pkg;
   // Clock and flash step timing
   localparam int unsigned PCLK_HZ        = 25_000_000;
   localparam int unsigned FLASH_STEP_US  = 32_000;
   localparam int unsigned FLASH_STEP_CYC = (PCLK_HZ / 1_000_000) * FLASH_STEP_US;

   // Register byte offsets
   localparam logic [7:0] GP_OFS     = 8'h00;
   localparam logic [7:0] CURR_OFS   = 8'h04;
   localparam logic [7:0] OPT_OFS    = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;

   // General purpose register fields
   localparam int GP_TORCH_BIT  = 0;
   localparam int GP_FLASH_BIT  = 1;
   localparam int GP_CHARGE_BIT = 2;
   localparam int GP_SEL_LO_BIT = 3;
   localparam int GP_SEL_HI_BIT = 4;
   localparam int GP_GATE_BIT   = 5;
   localparam logic [5:0] GP_RESET = 6'h00;

   // Current control register fields
   localparam int CURR_TORCH_LSB = 0;
   localparam int CURR_FLASH_LSB = 4;
   localparam logic [6:0] CURR_RESET = 7'h00;

   // Options register fields
   localparam int OPT_DUR_LSB   = 0;
   localparam int OPT_HEAD_LSB  = 4;
   localparam int OPT_LEVEL_BIT = 7;
   localparam logic [7:0] OPT_RESET = 8'h0F;

   // Charge target selection codes
   localparam logic [1:0] TGT_4V5     = 2'h0;
   localparam logic [1:0] TGT_5V0     = 2'h1;
   localparam logic [1:0] TGT_5V3     = 2'h2;
   localparam logic [1:0] TGT_OPTIMAL = 2'h3;

   // Torch code for the 60 mA floor
   localparam logic [2:0] TORCH_MIN = 3'h0;

   typedef enum logic [4:0] {
      ST_SHUTDOWN = 5'b00001,
      ST_TORCH    = 5'b00010,
      ST_CHARGE   = 5'b00100,
      ST_CHTORCH  = 5'b01000,
      ST_FLASH    = 5'b10000
   } fcmc_state_t;

   typedef enum logic [1:0] {
      REG_OFF    = 2'h0,
      REG_CURLIM = 2'h1,
      REG_CONSTF = 2'h2,
      REG_PULSED = 2'h3
   } fcmc_regmode_t;

   // Analog comparator results
   typedef struct packed {
      logic above_3v;
      logic at_target;
      logic below_turnon;
      logic load_over_60ma;
      logic demand_over_max;
   } fcmc_sense_t;

   // Power stage steering
   typedef struct packed {
      fcmc_regmode_t pulsed_regulation_scheme;
      logic          led_sink_output;
      logic [2:0]    torch_level;
      logic          flash_on;
      logic [2:0]    flash_level_field;
      logic [1:0]    charge_target_sel;
      logic [2:0]    torch_headroom_voltage;
   } fcmc_drive_t;
endpackage

// >>> hw/fcmc_top.sv
`timescale 1ns/1ps
module fcmc_top #(
   parameter int unsigned STEP_CYC = fcmc_pkg::FLASH_STEP_CYC
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                strobe,
   input  wire fcmc_pkg::fcmc_sense_t sense_raw,
   output fcmc_pkg::fcmc_state_t    state,
   output fcmc_pkg::fcmc_drive_t    drive,
   output logic                     eoc_n_o,
   output logic                     eoc_n_oe
);
   import fcmc_pkg::*;

   function automatic logic is_mapped(input logic [7:0] a);
      return a == GP_OFS || a == CURR_OFS || a == OPT_OFS || a == STATUS_OFS;
   endfunction

   logic [5:0]  gp_q;
   logic [6:0]  curr_q;
   logic [7:0]  opt_q;
   fcmc_state_t state_q, state_d;
   fcmc_sense_t sense_m_q, sense_q;
   logic [1:0]  strobe_m_q;
   logic        strobe_q, strobe_prev_q;
   logic        by_reg_q, opt_glow_q, pump_on_q, eoc_q;
   logic [23:0] step_cnt_q;
   logic [3:0]  steps_q;
   logic        wr, rd, flash_req, flash_done, strobe_rise, gate_ok, optimal;
   logic        torch_b, flash_b, charge_b, level_mode;

   // Input synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_m_q     <= '0;
         sense_q       <= '0;
         strobe_m_q    <= 2'h0;
         strobe_q      <= 1'b0;
         strobe_prev_q <= 1'b0;
      end else begin
         sense_m_q     <= sense_raw;
         sense_q       <= sense_m_q;
         strobe_m_q    <= {strobe_m_q[0], strobe};
         strobe_q      <= strobe_m_q[1];
         strobe_prev_q <= strobe_q;
      end
   end

   assign wr          = psel && penable && pwrite;
   assign rd          = psel && !penable && !pwrite;
   assign pready      = 1'b1;
   assign pslverr     = psel && penable && !is_mapped(paddr);
   assign torch_b     = gp_q[GP_TORCH_BIT];
   assign flash_b     = gp_q[GP_FLASH_BIT];
   assign charge_b    = gp_q[GP_CHARGE_BIT];
   assign level_mode  = opt_q[OPT_LEVEL_BIT];
   assign optimal     = {gp_q[GP_SEL_HI_BIT], gp_q[GP_SEL_LO_BIT]} == TGT_OPTIMAL;
   assign strobe_rise = strobe_q && !strobe_prev_q;
   assign gate_ok     = eoc_q || gp_q[GP_GATE_BIT];
   // Edge or level strobe, or register bit
   // Both strobe modes start on a rise, so a held strobe cannot retrigger after timeout
   assign flash_req   = gate_ok && (flash_b || strobe_rise);
   assign flash_done  = state_q == ST_FLASH && ((steps_q == opt_q[3:0] &&
                        step_cnt_q == 24'(STEP_CYC - 1)) ||
                        (!by_reg_q && level_mode && !strobe_q));

   // Register writes; hardware clears lose to a same-cycle write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gp_q <= GP_RESET;
      end else if (wr && paddr == GP_OFS) begin
         gp_q <= pwdata[5:0];
      end else if (flash_done && by_reg_q) begin
         gp_q[GP_TORCH_BIT] <= 1'b0;
         gp_q[GP_FLASH_BIT] <= 1'b0;
         if (optimal) begin
            gp_q[GP_CHARGE_BIT] <= 1'b0;
         end
      end else if (flash_done && optimal) begin
         gp_q[GP_CHARGE_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         curr_q <= CURR_RESET;
      end else if (wr && paddr == CURR_OFS) begin
         curr_q <= pwdata[6:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_q <= OPT_RESET;
      end else if (wr && paddr == OPT_OFS) begin
         opt_q <= pwdata[7:0];
      end
   end

   // Read data captured in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd) begin
         case (paddr)
            GP_OFS:     prdata <= {26'h0, gp_q};
            CURR_OFS:   prdata <= {25'h0, curr_q};
            OPT_OFS:    prdata <= {24'h0, opt_q};
            STATUS_OFS: prdata <= {24'h0, opt_glow_q, pump_on_q, eoc_q, state_q};
            default:    prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Next state from enables, strobe and charge status
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_FLASH: begin
            if (flash_done) begin
               state_d = ST_SHUTDOWN;
            end
         end
         ST_SHUTDOWN, ST_TORCH, ST_CHARGE, ST_CHTORCH: begin
            if (flash_req) begin
               state_d = ST_FLASH;
            end else if (torch_b && charge_b && !flash_b) begin
               state_d = ST_CHTORCH;
            end else if (torch_b && !charge_b && !flash_b) begin
               state_d = ST_TORCH;
            end else if (charge_b && !torch_b && !flash_b) begin
               state_d = ST_CHARGE;
            end else if (!strobe_q && !flash_b && !torch_b && !charge_b) begin
               state_d = ST_SHUTDOWN;
            end
         end
         default: state_d = ST_SHUTDOWN;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_SHUTDOWN;
      end else begin
         state_q <= state_d;
      end
   end

   // Flash duration timer and trigger source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_cnt_q <= 24'h000000;
         steps_q    <= 4'h0;
         by_reg_q   <= 1'b0;
      end else if (state_q != ST_FLASH) begin
         step_cnt_q <= 24'h000000;
         steps_q    <= 4'h0;
         by_reg_q   <= flash_b;
      end else if (step_cnt_q == 24'(STEP_CYC - 1)) begin
         step_cnt_q <= 24'h000000;
         steps_q    <= steps_q + 4'h1;
      end else begin
         step_cnt_q <= step_cnt_q + 24'h000001;
      end
   end

   // Pulsed pump: off at target, on below turn-on threshold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pump_on_q <= 1'b1;
      end else if (sense_q.below_turnon) begin
         pump_on_q <= 1'b1;
      end else if (sense_q.at_target) begin
         pump_on_q <= 1'b0;
      end
   end

   // Optimal mode glow latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_glow_q <= 1'b0;
      end else if (state_q == ST_SHUTDOWN || state_q == ST_FLASH || !optimal) begin
         opt_glow_q <= 1'b0;
      end else if (state_q == ST_CHARGE && sense_q.above_3v) begin
         opt_glow_q <= 1'b1;
      end
   end

   // End of charge flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eoc_q <= 1'b0;
      end else begin
         eoc_q <= (state_q == ST_CHARGE || state_q == ST_CHTORCH) && sense_q.at_target;
      end
   end

   // Power stage steering
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive <= '0;
      end else begin
         drive.charge_target_sel      <= {gp_q[GP_SEL_HI_BIT], gp_q[GP_SEL_LO_BIT]};
         drive.torch_headroom_voltage <= opt_q[6:4];
         drive.flash_level_field      <= curr_q[6:4];
         drive.flash_on               <= state_q == ST_FLASH;
         drive.torch_level            <= curr_q[2:0];
         drive.led_sink_output        <= 1'b0;
         drive.pulsed_regulation_scheme <= REG_OFF;
         case (state_q)
            ST_TORCH: begin
               drive.led_sink_output <= sense_q.above_3v;
               drive.pulsed_regulation_scheme <= pump_on_q ? REG_CURLIM : REG_OFF;
            end
            ST_CHARGE, ST_CHTORCH: begin
               if (state_q == ST_CHTORCH) begin
                  drive.led_sink_output <= sense_q.above_3v;
                  if (!sense_q.at_target) begin
                     drive.torch_level <= TORCH_MIN;
                  end
               end else begin
                  drive.led_sink_output <= opt_glow_q;
               end
               if (optimal) begin
                  drive.pulsed_regulation_scheme <= REG_PULSED;
               end else if (!sense_q.at_target || sense_q.demand_over_max) begin
                  drive.pulsed_regulation_scheme <= REG_CURLIM;
               end else begin
                  drive.pulsed_regulation_scheme <=
                     sense_q.load_over_60ma ? REG_CONSTF : REG_PULSED;
               end
            end
            default: begin
               drive.pulsed_regulation_scheme <= REG_OFF;
            end
         endcase
      end
   end

   assign state    = state_q;
   assign eoc_n_o  = 1'b0;
   assign eoc_n_oe = eoc_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_reg_flash_end;
      state_q == ST_FLASH && by_reg_q && flash_done;
   endsequence

   a_reset_state: assert property ($rose(presetn) |-> state_q == ST_SHUTDOWN)
      else $error("state not shutdown after reset");
   a_idle_shutdown: assert property (state_q != ST_FLASH && !flash_req && !strobe_q && gp_q == 6'h00
      |=> state_q == ST_SHUTDOWN)
      else $error("idle did not reach shutdown");
   a_torch_select: assert property (state_q == ST_SHUTDOWN && !flash_req && torch_b && !flash_b
      && !charge_b |=> state_q == ST_TORCH)
      else $error("torch state not selected");
   a_charge_select: assert property (state_q != ST_FLASH && !flash_req && charge_b && !flash_b
      && !torch_b |=> state_q == ST_CHARGE)
      else $error("charge state not selected");
   a_flash_entry: assert property (state_q != ST_FLASH && flash_req |=> state_q == ST_FLASH)
      else $error("flash request not taken");
   a_flash_clear: assert property (s_reg_flash_end ##0 !wr |=> !flash_b && !torch_b)
      else $error("flash and torch bits not cleared");
   a_level_end: assert property (state_q == ST_FLASH && !by_reg_q && level_mode && !strobe_q
      |=> state_q == ST_SHUTDOWN)
      else $error("level strobe flash not ended");
   a_torch_cap: assert property (state_q == ST_CHTORCH && !sense_q.at_target
      |=> drive.torch_level == TORCH_MIN)
      else $error("torch not capped while charging");
   a_led_3v: assert property (state_q == ST_TORCH && !sense_q.above_3v |=> !drive.led_sink_output)
      else $error("led sinks below 3 V");
   a_eoc_torch: assert property (state_q == ST_TORCH |=> ##1 !eoc_n_oe || state_q != ST_TORCH)
      else $error("end of charge shown in torch");
   a_step_limit: assert property (state_q == ST_FLASH |-> steps_q <= opt_q[3:0])
      else $error("flash ran past its duration");
endmodule

// >>> testbench/fcmc_cap_model.sv
`timescale 1ns/1ps
module fcmc_cap_model (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire fcmc_pkg::fcmc_state_t state,
   input  wire fcmc_pkg::fcmc_drive_t drive,
   output fcmc_pkg::fcmc_sense_t      sense
);
   import fcmc_pkg::*;
   logic [5:0] lvl_q;
   logic [1:0] div_q;
   logic       pump;

   assign pump = (drive.pulsed_regulation_scheme != REG_OFF) && (div_q == 2'h3);

   // Pump raises the level every fourth cycle; flash and shutdown drain it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_q <= 6'h00;
         div_q <= 2'h0;
      end else begin
         div_q <= div_q + 2'h1;
         if ((drive.flash_on || state == ST_SHUTDOWN) && lvl_q != 6'h00) begin
            lvl_q <= lvl_q - 6'h01;
         end else if (pump && lvl_q != 6'h3F) begin
            lvl_q <= lvl_q + 6'h01;
         end
      end
   end

   assign sense.above_3v        = (lvl_q >= 6'h08);
   assign sense.at_target       = (lvl_q >= 6'h18);
   assign sense.below_turnon    = (lvl_q < 6'h14);
   assign sense.load_over_60ma  = drive.led_sink_output;
   assign sense.demand_over_max = 1'b0;
endmodule

// >>> testbench/fcmc_tb_top.sv
`timescale 1ns/1ps
module fcmc_tb_top;
   import fcmc_pkg::*;
   localparam int unsigned STEP = 4;
   logic        pclk, presetn, psel, penable, pwrite, strobe;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, eoc_n_o, eoc_n_oe;
   fcmc_sense_t sense_raw;
   fcmc_state_t state;
   fcmc_drive_t drive;
   int          error_cnt, total_checks;

   fcmc_top #(.STEP_CYC(STEP)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .strobe(strobe), .sense_raw(sense_raw),
      .state(state), .drive(drive), .eoc_n_o(eoc_n_o), .eoc_n_oe(eoc_n_oe));

   fcmc_cap_model u_cap (.pclk(pclk), .presetn(presetn), .state(state),
      .drive(drive), .sense(sense_raw));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s exp %0h got %0h", nm, e, g);
      end
   endtask

   task automatic tick();
      @(posedge pclk);
      #1;
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      bus(1'b1, a, d, r, e);
   endtask

   task automatic wait_st(input fcmc_state_t s);
      for (int w = 0; w < 600 && state !== s; w++) tick();
      chk("state", s, state);
   endtask

   task automatic wait_eoc();
      for (int w = 0; w < 600 && eoc_n_oe !== 1'b1; w++) tick();
      chk("eoc", 1, eoc_n_oe);
      chk("eoc_pin", 0, eoc_n_o);
   endtask

   task automatic idle();
      wr(GP_OFS, 32'h00);
      wait_st(ST_SHUTDOWN);
      repeat (70) tick();
   endtask

   // Counts cycles spent in flash; checks the drive on the first one
   task automatic flash_len(output int n);
      for (int w = 0; w < 100 && state !== ST_FLASH; w++) tick();
      n = 0;
      while (state === ST_FLASH && n < 200) begin
         n++;
         tick();
         if (n == 1) begin
            chk("flash_on", 1, drive.flash_on);
            chk("flash_lvl", 3'h6, drive.flash_level_field);
         end
      end
   endtask

   task automatic t_reset();
      logic [31:0] r;
      logic        e;
      chk("rst_state", ST_SHUTDOWN, state);
      chk("rst_drive", 0, drive);
      bus(1'b0, OPT_OFS, 0, r, e);
      chk("opt_rst", 32'h0F, r);
      bus(1'b0, 8'h10, 0, r, e);
      chk("bad_err", 1, e);
      chk("bad_data", 0, r);
      $display("test reset done");
   endtask

   task automatic t_torch();
      idle();
      wr(CURR_OFS, 32'h65);
      wr(GP_OFS, 32'h01);
      wait_st(ST_TORCH);
      tick();
      chk("led_early", 0, drive.led_sink_output);
      chk("torch_lvl", 3'h5, drive.torch_level);
      chk("pump_on", REG_CURLIM, drive.pulsed_regulation_scheme);
      for (int w = 0; w < 600 && drive.led_sink_output !== 1'b1; w++) tick();
      chk("led_on", 1, drive.led_sink_output);
      for (int w = 0; w < 600 && drive.pulsed_regulation_scheme !== REG_OFF; w++) tick();
      chk("pump_off", REG_OFF, drive.pulsed_regulation_scheme);
      chk("eoc_torch", 0, eoc_n_oe);
      $display("test torch done");
   endtask

   task automatic t_charge();
      for (int c = 0; c < 4; c++) begin
         idle();
         wr(OPT_OFS, 32'h31);
         wr(GP_OFS, 32'h04 | (c << 3));
         wait_st(ST_CHARGE);
         tick();
         chk("target", c[1:0], drive.charge_target_sel);
         chk("headroom", 3'h3, drive.torch_headroom_voltage);
         if (c < 3) chk("curlim", REG_CURLIM, drive.pulsed_regulation_scheme);
         wait_eoc();
         repeat (3) tick();
         if (c < 3) chk("burst", REG_PULSED, drive.pulsed_regulation_scheme);
         else chk("glow", 1, drive.led_sink_output);
      end
      wr(GP_OFS, 32'h00);
      wait_st(ST_SHUTDOWN);
      tick();
      chk("glow_off", 0, drive.led_sink_output);
      $display("test charge done");
   endtask

   task automatic t_chtorch();
      logic [31:0] r;
      logic        e;
      idle();
      wr(GP_OFS, 32'h0D);
      wait_st(ST_CHTORCH);
      tick();
      chk("torch_cap", TORCH_MIN, drive.torch_level);
      wait_eoc();
      repeat (2) tick();
      chk("torch_full", 3'h5, drive.torch_level);
      bus(1'b0, STATUS_OFS, 0, r, e);
      chk("status", 32'h28, r);
      $display("test charge_torch done");
   endtask

   task automatic t_regflash();
      int          n;
      logic [31:0] r;
      logic        e;
      idle();
      wr(OPT_OFS, 32'h01);
      wr(GP_OFS, 32'h04);
      wait_eoc();
      wr(GP_OFS, 32'h07);
      flash_len(n);
      chk("reg_len", 2 * STEP, n);
      wait_st(ST_CHARGE);
      bus(1'b0, GP_OFS, 0, r, e);
      chk("gp_clear", 32'h04, r);
      $display("test reg_flash done");
   endtask

   task automatic strobe_hi(input int len);
      @(posedge pclk);
      strobe <= 1'b1;
      fork
         begin
            repeat (len) @(posedge pclk);
            strobe <= 1'b0;
         end
      join_none
   endtask

   task automatic t_strobe();
      int n;
      idle();
      wr(OPT_OFS, 32'h01);
      strobe_hi(30);
      repeat (10) tick();
      chk("gated", ST_SHUTDOWN, state);
      repeat (30) tick();
      wr(GP_OFS, 32'h20);
      strobe_hi(40);
      flash_len(n);
      chk("edge_len", 2 * STEP, n);
      repeat (4) tick();
      chk("edge_once", ST_SHUTDOWN, state);
      repeat (40) tick();
      wr(OPT_OFS, 32'h81);
      strobe_hi(4);
      flash_len(n);
      chk("lvl_short", 1, n > 0 && n < 2 * STEP);
      repeat (10) tick();
      strobe_hi(40);
      flash_len(n);
      chk("lvl_max", 2 * STEP, n);
      repeat (4) tick();
      chk("lvl_off", ST_SHUTDOWN, state);
      $display("test strobe done");
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #1_000_000;
      error_cnt++;
      close_out();
   end

   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      strobe  = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      tick();
      t_reset();
      t_torch();
      t_charge();
      t_chtorch();
      t_regflash();
      t_strobe();
      close_out();
   end
endmodule
